//--- rtl/tpr_pkg.sv
package tpr_pkg;
  localparam int TPR_LINES    = 32;
  localparam int TPR_WAYS     = 2;
  localparam int TPR_ENTRIES  = TPR_LINES * TPR_WAYS;
  localparam int TPR_WORDS    = TPR_ENTRIES * 2;
  localparam int TPR_IDX_W    = 10;
  localparam int TPR_PID_W    = 8;

  // Register byte offsets (word aligned)
  localparam logic [11:0] TPR_OFS_CTRL    = 12'h000;
  localparam logic [11:0] TPR_OFS_PROC    = 12'h004;
  localparam logic [11:0] TPR_OFS_ENTIDX  = 12'h008;
  localparam logic [11:0] TPR_OFS_ENTDATA = 12'h00c;
  localparam logic [11:0] TPR_OFS_ACCADDR = 12'h010;
  localparam logic [11:0] TPR_OFS_ACCCTL  = 12'h014;
  localparam logic [11:0] TPR_OFS_STATUS  = 12'h018;
  localparam logic [11:0] TPR_OFS_REPL    = 12'h01c;
  localparam logic [11:0] TPR_OFS_PC1     = 12'h020;
  localparam logic [11:0] TPR_OFS_CHADDR  = 12'h024;
  localparam logic [11:0] TPR_OFS_CHCTL   = 12'h028;
  localparam logic [11:0] TPR_OFS_RESULT  = 12'h02c;

  // Word 0 fields
  localparam int TPR_VE_BIT   = 0;
  localparam int TPR_TAG_LSB  = 1;
  localparam int TPR_SR_BIT   = 9;
  localparam int TPR_SW_BIT   = 10;
  localparam int TPR_SE_BIT   = 11;
  localparam int TPR_UR_BIT   = 12;
  localparam int TPR_UW_BIT   = 13;
  localparam int TPR_UE_BIT   = 14;
  localparam int TPR_VTAG_LSB = 15;

  // Access control register and control register fields
  localparam int TPR_AC_KIND_LSB = 0;
  localparam int TPR_AC_SUP_BIT  = 2;
  localparam int TPR_AC_BYP_BIT  = 3;
  localparam int TPR_AC_GO_BIT   = 4;
  localparam int TPR_CTRL_MOVE_BIT = 0;
  localparam int TPR_CTRL_EXT_BIT  = 1;

  // Trap vectors
  localparam logic [7:0] TPR_VEC_UIMISS = 8'h08;
  localparam logic [7:0] TPR_VEC_UDMISS = 8'h09;
  localparam logic [7:0] TPR_VEC_SIMISS = 8'h0a;
  localparam logic [7:0] TPR_VEC_SDMISS = 8'h0b;
  localparam logic [7:0] TPR_VEC_IPROT  = 8'h0c;
  localparam logic [7:0] TPR_VEC_DPROT  = 8'h0d;

  localparam logic [31:0] TPR_ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    TPR_ACC_LOAD  = 2'b00,
    TPR_ACC_STORE = 2'b01,
    TPR_ACC_FETCH = 2'b10,
    TPR_ACC_ATOM  = 2'b11
  } tpr_kind_type;
endpackage : tpr_pkg

//--- rtl/tpr_permit.sv
`timescale 1ns/1ps
module tpr_permit
  import tpr_pkg::*;
(
  // Access
  input  wire logic [1:0] kind,
  input  wire logic       supervisor_flag,
  input  wire logic       bypass,
  // Permission bits
  input  wire logic [5:0] permits,
  // Result
  output logic            allowed
);
  wire logic [2:0] mode_bits = supervisor_flag ? permits[2:0] : permits[5:3];
  wire logic       rd        = mode_bits[0];
  wire logic       wr        = mode_bits[1];
  wire logic       ex        = mode_bits[2];
  wire logic       chk       = (kind == TPR_ACC_LOAD)  ? rd :
                               (kind == TPR_ACC_STORE) ? wr :
                               (kind == TPR_ACC_FETCH) ? ex : (rd & wr);
  assign allowed = bypass | chk;
endmodule : tpr_permit

//--- rtl/tpr_core.sv
`timescale 1ns/1ps
module tpr_core
  import tpr_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Trap and pipeline
  output logic             trap_ff,
  output logic [7:0]       trap_vector_ff,
  output logic             pipeline_hold_ff
);
  import tpr_pkg::*;

  logic [31:0] xlate_mem [TPR_WORDS];
  logic [TPR_PID_W-1:0] process_number_ff;
  logic [TPR_IDX_W-1:0] ent_idx_ff;
  logic [31:0] ent_data_ff, acc_addr_ff, result_ff, repl_ff, pc1_ff, chaddr_ff, chctl_ff;
  logic [4:0]  acc_ctl_ff;
  logic        move_pend_ff, ctl_ext_ff;
  logic [4:0]  victim_ff;
  logic        hit_ff, viol_ff;

  // Bus address phase capture
  logic        ph_valid_ff, ph_write_ff;
  logic [11:0] ph_addr_ff;
  logic [31:0] hrdata_ff;
  logic        rd_wait_ff, hreadyout_ff, hresp_ff;
  wire logic   addr_take = hsel & hready & htrans[1];
  wire logic   wr_go     = ph_valid_ff & ph_write_ff;
  wire logic   wr_ctrl   = wr_go & (ph_addr_ff == TPR_OFS_CTRL);
  wire logic   wr_proc   = wr_go & (ph_addr_ff == TPR_OFS_PROC);
  wire logic   wr_idx    = wr_go & (ph_addr_ff == TPR_OFS_ENTIDX);
  wire logic   wr_data   = wr_go & (ph_addr_ff == TPR_OFS_ENTDATA);
  wire logic   wr_aaddr  = wr_go & (ph_addr_ff == TPR_OFS_ACCADDR);
  wire logic   wr_actl   = wr_go & (ph_addr_ff == TPR_OFS_ACCCTL);
  wire logic   move_in_req  = wr_ctrl & hwdata[TPR_CTRL_MOVE_BIT];
  wire logic   move_from_req = wr_ctrl & ~hwdata[TPR_CTRL_MOVE_BIT] & hwdata[3];
  wire logic   acc_go    = wr_actl & hwdata[TPR_AC_GO_BIT];
  wire logic   rd_take   = addr_take & ~hwrite;
  wire logic   rd_clash  = rd_take & wr_go;
  wire logic [11:0] rd_sel = rd_wait_ff ? ph_addr_ff : haddr[11:0];

  // Translation lookup: line from address bits 14-10, two ways
  wire logic [4:0]  line      = acc_addr_ff[14:10];
  wire logic [6:0]  w0_way0   = {line, 2'b00};
  wire logic [6:0]  w0_way1   = {line, 2'b10};
  wire logic [31:0] e0        = xlate_mem[w0_way0];
  wire logic [31:0] e1        = xlate_mem[w0_way1];

  function automatic logic entry_hit(input logic [31:0] w, input logic [7:0] process_number, input logic [16:0] vt);
    entry_hit = w[TPR_VE_BIT] & (w[TPR_TAG_LSB +: 8] == process_number) & (w[TPR_VTAG_LSB +: 17] == vt);
  endfunction : entry_hit

  wire logic [16:0] vtag    = acc_addr_ff[31:15];
  wire logic        hit0    = entry_hit(e0, process_number_ff, vtag);
  wire logic        hit1    = entry_hit(e1, process_number_ff, vtag);
  wire logic        hit     = hit0 | hit1;
  wire logic [31:0] hent    = hit0 ? e0 : e1;
  wire logic [5:0]  permits = {hent[TPR_UE_BIT], hent[TPR_UW_BIT], hent[TPR_UR_BIT],
                               hent[TPR_SE_BIT], hent[TPR_SW_BIT], hent[TPR_SR_BIT]};
  wire logic [1:0]  kind    = acc_ctl_ff[1:0];
  wire logic        sup     = acc_ctl_ff[TPR_AC_SUP_BIT];
  wire logic        byp     = acc_ctl_ff[TPR_AC_BYP_BIT];
  wire logic        is_fetch = (kind == TPR_ACC_FETCH);
  logic             allowed;

  tpr_permit u_permit (
    .kind            (kind),
    .supervisor_flag (sup),
    .bypass          (byp),
    .permits         (permits),
    .allowed         (allowed)
  );

  // Miss vector by mode and kind; no self-fill, software reloads
  wire logic [7:0] miss_vec = sup ? (is_fetch ? TPR_VEC_SIMISS : TPR_VEC_SDMISS)
                                  : (is_fetch ? TPR_VEC_UIMISS : TPR_VEC_UDMISS);
  wire logic [7:0] prot_vec = is_fetch ? TPR_VEC_IPROT : TPR_VEC_DPROT;
  wire logic       miss     = ~byp & ~hit;
  wire logic       viol     = ~byp & hit & ~allowed;
  wire logic [6:0] repl_w0  = {line, victim_ff[0], 1'b0};

  // Check stage, one cycle after the go pulse
  logic chk_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_ff <= 1'b0;
    end else begin
      chk_ff <= acc_go;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_ff        <= 1'b0;
      trap_vector_ff <= 8'h00;
      hit_ff         <= 1'b0;
      viol_ff        <= 1'b0;
      repl_ff        <= TPR_ZERO32;
      pc1_ff         <= TPR_ZERO32;
      chaddr_ff      <= TPR_ZERO32;
      chctl_ff       <= TPR_ZERO32;
      victim_ff      <= 5'h00;
    end else begin
      trap_ff <= 1'b0;
      victim_ff <= victim_ff + 5'h01;
      if (chk_ff) begin
        hit_ff  <= hit;
        viol_ff <= viol;
        if (miss) begin
          trap_ff        <= 1'b1;
          trap_vector_ff <= miss_vec;
          repl_ff        <= {22'h00_0000, 3'b000, repl_w0};
          if (is_fetch) begin
            pc1_ff <= acc_addr_ff;
          end else begin
            chaddr_ff <= acc_addr_ff;
            chctl_ff  <= {27'h000_0000, acc_ctl_ff};
          end
        end else if (viol) begin
          trap_ff        <= 1'b1;
          trap_vector_ff <= prot_vec;
          if (is_fetch) begin
            pc1_ff <= acc_addr_ff;
          end else begin
            chaddr_ff <= acc_addr_ff;
            chctl_ff  <= {27'h000_0000, acc_ctl_ff};
          end
        end
      end
    end
  end

  // Entry access with the entry write serialized against the external access; entry reads are not
  wire logic do_move_in = (move_in_req & ~ctl_ext_ff) | (move_pend_ff & ~ctl_ext_ff);
  wire logic [31:0] ent_word = xlate_mem[ent_idx_ff[6:0]];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      move_pend_ff     <= 1'b0;
      pipeline_hold_ff <= 1'b0;
    end else begin
      move_pend_ff     <= (move_in_req | move_pend_ff) & ctl_ext_ff;
      pipeline_hold_ff <= (move_in_req | move_pend_ff) & ctl_ext_ff;
    end
  end

  always_ff @(posedge hclk) begin
    if (do_move_in) begin
      xlate_mem[ent_idx_ff[6:0]] <= ent_data_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_ff <= TPR_ZERO32;
    end else if (move_from_req) begin
      result_ff <= ent_word;
    end
  end

  // Software-written registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      process_number_ff <= 8'h00;
      ent_idx_ff        <= 10'h000;
      ent_data_ff       <= TPR_ZERO32;
      acc_addr_ff       <= TPR_ZERO32;
      acc_ctl_ff        <= 5'h00;
      ctl_ext_ff        <= 1'b0;
    end else begin
      if (wr_proc) begin
        process_number_ff <= hwdata[7:0];
      end
      if (wr_idx) begin
        ent_idx_ff <= hwdata[9:0];
      end
      if (wr_data) begin
        ent_data_ff <= hwdata;
      end
      if (wr_aaddr) begin
        acc_addr_ff <= hwdata;
      end
      if (wr_actl) begin
        acc_ctl_ff <= hwdata[4:0];
      end
      if (wr_ctrl) begin
        ctl_ext_ff <= hwdata[TPR_CTRL_EXT_BIT];
      end
    end
  end

  // Bus phase tracking
  wire logic [31:0] rd_mux =
      (rd_sel == TPR_OFS_CTRL)    ? {31'h0000_0000, ctl_ext_ff} << 1 :
      (rd_sel == TPR_OFS_PROC)    ? {24'h00_0000, process_number_ff} :
      (rd_sel == TPR_OFS_ENTIDX)  ? {22'h00_0000, ent_idx_ff} :
      (rd_sel == TPR_OFS_ENTDATA) ? ent_data_ff :
      (rd_sel == TPR_OFS_ACCADDR) ? acc_addr_ff :
      (rd_sel == TPR_OFS_ACCCTL)  ? {27'h000_0000, acc_ctl_ff} :
      (rd_sel == TPR_OFS_STATUS)  ? {29'h0000_0000, viol_ff, hit_ff, pipeline_hold_ff} :
      (rd_sel == TPR_OFS_REPL)    ? repl_ff :
      (rd_sel == TPR_OFS_PC1)     ? pc1_ff :
      (rd_sel == TPR_OFS_CHADDR)  ? chaddr_ff :
      (rd_sel == TPR_OFS_CHCTL)   ? chctl_ff :
      (rd_sel == TPR_OFS_RESULT)  ? result_ff : TPR_ZERO32;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_ff <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff  <= 12'h000;
    end else begin
      ph_valid_ff <= addr_take;
      ph_write_ff <= hwrite;
      ph_addr_ff  <= haddr[11:0];
    end
  end

  // Read data leaves a flop; a read that meets a landing write waits one cycle
  // so that it returns the written value instead of the old one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_ff   <= 1'b0;
      hrdata_ff    <= TPR_ZERO32;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      rd_wait_ff   <= rd_clash;
      hreadyout_ff <= ~rd_clash;
      hresp_ff     <= 1'b0;
      hrdata_ff    <= (rd_wait_ff | (rd_take & ~wr_go)) ? rd_mux : TPR_ZERO32;
    end
  end
  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  a_miss_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && miss && !is_fetch && sup) |=> (trap_ff && trap_vector_ff == 8'h0b))
    else $error("supervisor data miss vector wrong");
  a_prot_trap: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && viol) |=> (trap_ff && trap_vector_ff >= 8'h0c))
    else $error("protection trap missing");
  a_bypass_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && byp) |=> !trap_ff)
    else $error("bypass raised trap");
  a_pc_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && miss && is_fetch) |=> (pc1_ff == $past(acc_addr_ff)))
    else $error("fetch miss address not kept");
  a_chan_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && miss && !is_fetch) |=> (chaddr_ff == $past(acc_addr_ff)))
    else $error("data miss address not kept");
  a_repl_line: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && miss) |=> (repl_ff[6:2] == $past(line) && repl_ff[0] == 1'b0))
    else $error("replacement index wrong");
  a_hold_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    (move_in_req && ctl_ext_ff) |=> pipeline_hold_ff)
    else $error("no hold while access busy");
  a_no_write_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl_ext_ff |=> (xlate_mem[$past(ent_idx_ff[6:0])] == $past(ent_word)))
    else $error("entry written during access");
  a_hit_needs_tag: assert property (@(posedge hclk) disable iff (!hresetn)
    hit0 |-> (e0[8:1] == process_number_ff && e0[0]))
    else $error("hit without tag match");
  a_sup_store: assert property (@(posedge hclk) disable iff (!hresetn)
    (!byp && sup && kind == TPR_ACC_STORE) |-> (allowed == permits[1]))
    else $error("supervisor store check wrong");
  a_atomic: assert property (@(posedge hclk) disable iff (!hresetn)
    (!byp && !sup && kind == TPR_ACC_ATOM) |-> (allowed == (permits[3] & permits[4])))
    else $error("atomic check wrong");

  // Bus answer and process number store
  a_rd_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_clash |=> (!hreadyout ##1 hreadyout))
    else $error("read after write did not wait once");
  a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !(rd_take || rd_wait_ff) |=> (hrdata == TPR_ZERO32))
    else $error("read data outside a read");
  a_proc_field: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_proc |=> (process_number_ff == $past(hwdata[7:0])))
    else $error("process number not stored");

  // Trap and capture
  a_no_self_fill: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && !do_move_in) |=> (xlate_mem[$past(w0_way0)] == $past(e0)))
    else $error("entry changed by a lookup");
  a_prot_vec: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && viol) |=> (trap_vector_ff == ($past(is_fetch) ? TPR_VEC_IPROT : TPR_VEC_DPROT)))
    else $error("protection vector wrong");
  a_chctl_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk_ff && viol && !is_fetch) |=> (chctl_ff[4:0] == $past(acc_ctl_ff)))
    else $error("violation attributes not kept");

  // Entry store and serialisation
  a_entry_write: assert property (@(posedge hclk) disable iff (!hresetn)
    do_move_in |=> (xlate_mem[$past(ent_idx_ff[6:0])] == $past(ent_data_ff)))
    else $error("entry write did not land");
  a_result_read: assert property (@(posedge hclk) disable iff (!hresetn)
    move_from_req |=> (result_ff == $past(ent_word)))
    else $error("entry read result wrong");
  a_hold_release: assert property (@(posedge hclk) disable iff (!hresetn)
    (pipeline_hold_ff && !ctl_ext_ff) |-> (do_move_in ##1 !pipeline_hold_ff))
    else $error("stalled write not resumed");

  // Permission decode
  a_sup_load: assert property (@(posedge hclk) disable iff (!hresetn)
    (!byp && sup && kind == TPR_ACC_LOAD) |-> (allowed == permits[0]))
    else $error("supervisor load check wrong");
  a_user_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
    (!byp && !sup && kind == TPR_ACC_FETCH) |-> (allowed == permits[5]))
    else $error("user fetch check wrong");
endmodule : tpr_core

//--- test/tpr_trap_seq.sv
`timescale 1ns/1ps
module tpr_trap_seq (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Trap request from the block
  input  wire logic        trap_ff,
  input  wire logic [7:0]  trap_vector_ff,
  // What the sequencer took
  output logic      [15:0] taken_ff,
  output logic      [7:0]  vec_ff
);
  // Vector and pulse leave the block on the same edge, so both are taken together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken_ff <= 16'h0000;
      vec_ff   <= 8'h00;
    end else if (trap_ff === 1'b1) begin
      taken_ff <= taken_ff + 16'h0001;
      vec_ff   <= trap_vector_ff;
    end
  end
endmodule : tpr_trap_seq

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tpr_pkg::*;
  localparam logic [31:0] ADR = 32'h1234_0400;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b1;
  logic        hwrite    = 1'b0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [1:0]  htrans    = 2'b00;
  logic [2:0]  hsize     = 3'b010;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        trap_ff;
  logic        pipeline_hold_ff;
  logic [7:0]  trap_vector_ff;
  logic [7:0]  vec;
  logic [15:0] taken;
  logic [15:0] n0;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  assign hready = hreadyout;

  tpr_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trap_ff(trap_ff), .trap_vector_ff(trap_vector_ff),
    .pipeline_hold_ff(pipeline_hold_ff));
  tpr_trap_seq i_seq (.hclk(hclk), .hresetn(hresetn), .trap_ff(trap_ff),
    .trap_vector_ff(trap_vector_ff), .taken_ff(taken), .vec_ff(vec));

  initial forever #10 hclk = ~hclk;

  // Budget covers every scenario several times over
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH %0t run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One single transfer; every signal held until hready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {20'h0_0000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk({31'h0000_0000, hresp}, TPR_ZERO32, "bus response okay");
  endtask : bus

  // Write then read of one register back to back; the read must see the new value
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr  <= {20'h0_0000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hwrite <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : wr_rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  function automatic logic [31:0] w0(input logic [31:0] a, input logic [7:0] t, input logic [5:0] m,
                                     input logic v);
    return {a[31:15], m, t, v};
  endfunction : w0

  task automatic put(input logic [31:0] i, input logic [31:0] d);
    wr(TPR_OFS_ENTIDX, i);
    wr(TPR_OFS_ENTDATA, d);
    wr(TPR_OFS_CTRL, 32'h0000_0001);
  endtask : put

  // Trap outcome read from the sequencer, never from the block's registers
  task automatic acc(input logic [31:0] a, input logic [4:0] c, input logic t, input logic [7:0] v);
    n0 = taken;
    wr(TPR_OFS_ACCADDR, a);
    wr(TPR_OFS_ACCCTL, {27'h000_0000, c} | 32'h0000_0010);
    repeat (4) @(posedge hclk);
    chk({31'h0000_0000, taken != n0}, {31'h0000_0000, t}, "trap raised");
    if (t) chk({24'h00_0000, vec}, {24'h00_0000, v}, "trap vector");
  endtask : acc

  task automatic t_reset;
    rd(TPR_OFS_STATUS, r);
    chk(r, TPR_ZERO32, "status at reset");
    wr(12'h030, 32'hffff_ffff);
    rd(12'h030, r);
    chk(r, TPR_ZERO32, "unmapped place");
    wr_rd(TPR_OFS_PROC, 32'h0000_0105, r);
    chk(r, 32'h0000_0005, "process number read after write");
    $display("test reset done");
  endtask : t_reset

  task automatic t_miss;
    logic [31:0] b;
    for (int k = 0; k < 4; k++) begin
      b = 32'h5678_0400 + 32'(4 * k);
      acc(b, {2'b00, k[1], ~k[0], 1'b0}, 1'b1, TPR_VEC_UIMISS + 8'(k));
      rd(TPR_OFS_REPL, r);
      chk(r & 32'hffff_fffd, 32'h0000_0004, "refill word 0");
      rd(k[0] ? TPR_OFS_CHADDR : TPR_OFS_PC1, r);
      chk(r, b, "miss address");
    end
    $display("test miss done");
  endtask : t_miss

  task automatic t_perm;
    logic [5:0] m;
    logic       ok;
    int         bs;
    for (int p = 0; p < 8; p++) begin
      m = (p < 6) ? 6'(1 << p) : (p == 6 ? 6'h03 : 6'h18);
      put(4, w0(ADR, 8'h05, m, 1'b1));
      for (int s = 0; s < 2; s++) begin
        for (int k = 0; k < 4; k++) begin
          bs = s ? 0 : 3;
          ok = (k == 0) ? m[bs] : (k == 1) ? m[bs+1] : (k == 2) ? m[bs+2] : m[bs] & m[bs+1];
          acc(ADR + 32'(4 * k), {2'b00, s[0], 2'(k)}, ~ok, k == 2 ? TPR_VEC_IPROT : TPR_VEC_DPROT);
          if (!ok) begin
            rd(k == 2 ? TPR_OFS_PC1 : TPR_OFS_CHADDR, r);
            chk(r, ADR + 32'(4 * k), "violation address");
            rd(TPR_OFS_CHCTL, r);
            if (k != 2) chk({28'h000_0000, r[3:0]}, {28'h000_0000, 1'b0, s[0], 2'(k)}, "violation attributes");
          end
        end
      end
    end
    put(4, w0(ADR, 8'h05, 6'h00, 1'b1));
    acc(ADR, 5'b01010, 1'b0, 8'h00);
    $display("test protection done");
  endtask : t_perm

  task automatic t_inval;
    put(4, w0(ADR, 8'h05, 6'h3f, 1'b1));
    acc(ADR, 5'b00000, 1'b0, 8'h00);
    rd(TPR_OFS_STATUS, r);
    chk({31'h0000_0000, r[1]}, 32'h0000_0001, "hit flag");
    wr(TPR_OFS_PROC, 32'h0000_0006);
    acc(ADR, 5'b00000, 1'b1, TPR_VEC_UDMISS);
    // Bits above the 8-bit field must not take part in the match
    wr(TPR_OFS_PROC, 32'h0000_0105);
    acc(ADR, 5'b00000, 1'b0, 8'h00);
    put(4, w0(ADR, 8'h05, 6'h3f, 1'b0));
    acc(ADR, 5'b00100, 1'b1, TPR_VEC_SDMISS);
    $display("test invalidation done");
  endtask : t_inval

  task automatic t_move;
    put(32'hffff_fc09, 32'ha5a5_0001);
    wr(TPR_OFS_ENTIDX, 32'h0000_0009);
    wr(TPR_OFS_CTRL, 32'h0000_0008);
    rd(TPR_OFS_RESULT, r);
    chk(r, 32'ha5a5_0001, "entry read back");
    wr(TPR_OFS_ENTDATA, 32'h0f0f_0002);
    wr(TPR_OFS_CTRL, 32'h0000_0002);
    wr(TPR_OFS_CTRL, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    chk({31'h0000_0000, pipeline_hold_ff}, 32'h0000_0001, "hold while busy");
    wr(TPR_OFS_CTRL, 32'h0000_000a);
    rd(TPR_OFS_RESULT, r);
    chk(r, 32'ha5a5_0001, "entry untouched while busy");
    wr(TPR_OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk({31'h0000_0000, pipeline_hold_ff}, 32'h0000_0000, "hold released");
    wr(TPR_OFS_CTRL, 32'h0000_0008);
    rd(TPR_OFS_RESULT, r);
    chk(r, 32'h0f0f_0002, "stalled write landed");
    $display("test move done");
  endtask : t_move

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    // Entry storage is not reset, so the partner way is written invalid first
    wr(TPR_OFS_PROC, 32'h0000_0005);
    put(6, 32'h0000_0000);
    put(4, w0(ADR, 8'h05, 6'h3f, 1'b1));
    t_miss();
    t_perm();
    t_inval();
    t_move();
    report_and_stop();
  end
endmodule : tb_top
